//--- design/ofr_link_sync.sv
/*
  Pin synchroniser and serial clock edge finder for the flash link.
  Assumes: link pins are asynchronous to clk_in and the serial clock is
  far slower than clk_in.
*/
`timescale 1ns/1ps
`default_nettype none

module ofr_link_sync (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pins
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic octal_mode_in,
  input wire logic [7:0] dq_in,
  // events
  output ofr_pkg::ofr_link_t link_out
);

  // ****************************************
  // two-flop synchronisers
  // ****************************************
  logic [10:0] s1_r;
  logic [10:0] s2_r;
  logic sck_d_r;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      s1_r <= 11'h001;
      s2_r <= 11'h001;
      sck_d_r <= 1'b0;
    end else begin
      s1_r <= {dq_in, octal_mode_in, sck_in, cs_n_in};
      s2_r <= s1_r;
      sck_d_r <= s2_r[1];
    end
  end

  assign link_out.act = ~s2_r[0];
  assign link_out.rise = ~s2_r[0] & s2_r[1] & ~sck_d_r;
  assign link_out.fall = ~s2_r[0] & ~s2_r[1] & sck_d_r;
  assign link_out.octal = s2_r[2];
  assign link_out.dq = s2_r[10:3];

endmodule

`default_nettype wire

//--- design/ofr_pkg.sv
/*
  Constants, types and the latency lookup for the octal flash register
  access block.
  Assumes: a 250 MHz system clock and a host-driven serial link.
*/
package ofr_pkg;

  // ****************************************
  // clock and timing
  // ****************************************
  localparam int CLK_MHZ = 250;
  localparam int OP_TIME_NS = 4000;
  localparam int OP_CYCLES = (OP_TIME_NS * CLK_MHZ) / 1000;

  // ****************************************
  // command codes
  // ****************************************
  localparam logic [7:0] CMD_WREN = 8'h06;
  localparam logic [7:0] CMD_WRDI = 8'h04;
  localparam logic [7:0] CMD_RDSR = 8'h05;
  localparam logic [7:0] CMD_RDREG = 8'h65;
  localparam logic [7:0] CMD_WRREG = 8'h71;
  localparam logic [7:0] CMD_RSTEN = 8'h66;
  localparam logic [7:0] CMD_RST = 8'h99;
  localparam logic [7:0] CMD_CLSR = 8'h82;
  localparam logic [7:0] CMD_SFDP = 8'h5a;
  localparam logic [7:0] CMD_PP = 8'h12;
  localparam logic [7:0] CMD_SE4K = 8'h21;
  localparam logic [7:0] CMD_CE = 8'h60;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [23:0] VOL_BASE = 24'h800000;
  localparam logic [23:0] NV_BASE = 24'h000000;
  localparam logic [23:0] REG_STAT1 = 24'h000000;
  localparam logic [23:0] REG_CFG2 = 24'h000003;
  localparam int ADDR_BYTES = 3;
  localparam int BIT_BUSY = 0;
  localparam int BIT_WEL = 1;
  localparam int BIT_EFAIL = 5;
  localparam int BIT_PFAIL = 6;
  localparam int LAT_LSB = 0;
  localparam int LAT_W = 4;
  localparam logic [7:0] CFG2_RESET = 8'h08;

  // ****************************************
  // latency settings
  // ****************************************
  localparam logic [4:0] VOL_DUMMY_OCT = 5'h03;
  localparam logic [4:0] VOL_DUMMY_SPI = 5'h00;
  localparam logic [4:0] NV_DUMMY_SPI = 5'h08;
  localparam logic [3:0] LAT_CODE_200 = 4'ha;
  localparam logic [3:0] LAT_CODE_166 = 4'h8;
  localparam logic [3:0] LAT_CODE_133 = 4'h5;
  localparam logic [3:0] LAT_CODE_100 = 4'h3;
  localparam logic [4:0] LAT_CYC_200 = 5'h17;
  localparam logic [4:0] LAT_CYC_166 = 5'h14;
  localparam logic [4:0] LAT_CYC_133 = 5'h0e;
  localparam logic [4:0] LAT_CYC_100 = 5'h0a;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [2:0] {
    ST_CMD, ST_ADDR, ST_DUMMY, ST_WDATA, ST_RDATA, ST_DONE, ST_IGNORE
  } ofr_state_t;

  typedef enum logic [1:0] {OP_NONE, OP_PROG, OP_ERASE, OP_NVW} ofr_op_t;

  typedef struct packed {
    logic act;
    logic rise;
    logic fall;
    logic octal;
    logic [7:0] dq;
  } ofr_link_t;

  // wait-state code to latency cycles
  function automatic logic [4:0] lat_cycles(input logic [3:0] code);
    case (code)
      LAT_CODE_200: lat_cycles = LAT_CYC_200;
      LAT_CODE_166: lat_cycles = LAT_CYC_166;
      LAT_CODE_133: lat_cycles = LAT_CYC_133;
      LAT_CODE_100: lat_cycles = LAT_CYC_100;
      default: lat_cycles = {code, 1'b0} + 5'h04;
    endcase
  endfunction

endpackage

//--- design/ofr_regs.sv
/*
  Register access engine of an octal serial NOR flash: command decode,
  status and latency registers, busy timing and read latency.
  Assumes: single-data-rate framing, the array reports failures on
  prog_fail_in and erase_fail_in in clk_in's domain.
*/
// Function
// - 200 MHz reads use 23 latency cycles, wait-state code 01010b.
// - 166 MHz reads use 20 latency cycles, wait-state code 01000b.
// - 133 MHz reads use 14 latency cycles, wait-state code 00101b.
// - 100 MHz reads use 10 latency cycles, wait-state code 00011b.
// - volatile register copies sit at local address plus 800000h.
// - non-volatile register copies sit at local address plus zero.
// - generic register read and write carry a three-byte address.
// - volatile register reads: 3 latency cycles octal, none single-wire.
// - non-volatile reads use configured latency octal, 8 latency cycles single-wire.
// - busy bit is read-only bit 0 of status one.
// - write latch is bit 1 of status one, set by 06h.
// - program failure flag at bit 6, zero unless last program failed.
// - erase failure flag at bit 5, zero unless last erase failed.
// - 4-bit latency field at bit 0 of configuration two, 71h/65h.
// - discoverable-parameter read accepted in octal mode.
// - 4 KB and chip erase supported, 32 KB erase not.
// - reset-enable then reset supported; no combined protocol reset.
// - clear-status command clears error flags; no flag-status read.
// - no wrapped burst read or wrap setup command.
`timescale 1ns/1ps
`default_nettype none

module ofr_regs #(
  parameter int OP_CYCLES = ofr_pkg::OP_CYCLES
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // serial link
  input wire logic cs_n_in,
  input wire logic sck_in,
  input wire logic octal_mode_in,
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  output logic dq_oe_n_out,
  // array results
  input wire logic prog_fail_in,
  input wire logic erase_fail_in,
  // state
  output logic op_busy_flag_out,
  output logic write_latch_flag_out,
  output logic [3:0] latency_code_out
);

  // ****************************************
  // link front end
  // ****************************************
  ofr_pkg::ofr_link_t lk;

  ofr_link_sync u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .cs_n_in(cs_n_in),
    .sck_in(sck_in),
    .octal_mode_in(octal_mode_in),
    .dq_in(dq_in),
    .link_out(lk)
  );

  // ****************************************
  // state
  // ****************************************
  ofr_pkg::ofr_state_t st_r, st_nxt;
  ofr_pkg::ofr_op_t op_r;
  logic act_d_r;
  logic [2:0] bcnt_r;
  logic [6:0] sh_r;
  logic [7:0] cmd_r;
  logic [23:0] addr_r;
  logic [1:0] acnt_r;
  logic [4:0] dcnt_r;
  logic [4:0] dlen_r;
  logic [7:0] wdat_r;
  logic [2:0] obit_r;
  logic [7:0] dq_r;
  logic oe_n_r;
  logic busy_r;
  logic wel_r;
  logic pfail_r;
  logic efail_r;
  logic arm_r;
  logic [7:0] cfg_nv_r;
  logic [7:0] cfg_v_r;
  logic [7:0] nvdat_r;
  logic [15:0] tmr_r;

  // ****************************************
  // byte assembly and decode
  // ****************************************
  wire rx_st = (st_r == ofr_pkg::ST_CMD) | (st_r == ofr_pkg::ST_ADDR)
               | (st_r == ofr_pkg::ST_WDATA);
  wire byte_done = lk.rise & rx_st & (lk.octal | (bcnt_r == 3'h7));
  wire [7:0] rx_byte = lk.octal ? lk.dq : {sh_r, lk.dq[0]};
  wire [23:0] addr_nxt = {addr_r[15:0], rx_byte};
  wire addr_last = byte_done & (st_r == ofr_pkg::ST_ADDR)
                   & (acnt_r == 2'(ofr_pkg::ADDR_BYTES - 1));
  wire nxt_vol = addr_nxt >= ofr_pkg::VOL_BASE;
  wire is_vol = addr_r >= ofr_pkg::VOL_BASE;
  wire [23:0] loc = addr_r - (is_vol ? ofr_pkg::VOL_BASE : ofr_pkg::NV_BASE);
  wire [3:0] lat_code = cfg_v_r[ofr_pkg::LAT_LSB +: ofr_pkg::LAT_W];
  wire [4:0] nv_dummy = lk.octal ? ofr_pkg::lat_cycles(lat_code)
                                 : ofr_pkg::NV_DUMMY_SPI;
  wire [4:0] vol_dummy = lk.octal ? ofr_pkg::VOL_DUMMY_OCT
                                  : ofr_pkg::VOL_DUMMY_SPI;
  wire [4:0] rd_dummy = (cmd_r == ofr_pkg::CMD_SFDP) ? ofr_pkg::NV_DUMMY_SPI
                        : (nxt_vol ? vol_dummy : nv_dummy);

  // ****************************************
  // read data
  // ****************************************
  logic [7:0] stat;
  always_comb begin
    stat = 8'h00;
    stat[ofr_pkg::BIT_BUSY] = busy_r;
    stat[ofr_pkg::BIT_WEL] = wel_r;
    stat[ofr_pkg::BIT_EFAIL] = efail_r;
    stat[ofr_pkg::BIT_PFAIL] = pfail_r;
  end

  wire loc_stat = loc == ofr_pkg::REG_STAT1;
  wire loc_cfg = loc == ofr_pkg::REG_CFG2;
  wire is_rdreg = cmd_r == ofr_pkg::CMD_RDREG;
  wire [7:0] rd_val = (cmd_r == ofr_pkg::CMD_RDSR) ? stat
                      : (is_rdreg & loc_stat) ? stat
                      : (is_rdreg & loc_cfg) ? (is_vol ? cfg_v_r : cfg_nv_r)
                      : 8'h00;

  // ****************************************
  // frame state machine
  // ****************************************
  always_comb begin
    st_nxt = st_r;
    if (!lk.act) begin
      st_nxt = ofr_pkg::ST_CMD;
    end else begin
      case (st_r)
        ofr_pkg::ST_CMD: begin
          if (byte_done) begin
            case (rx_byte)
              ofr_pkg::CMD_WREN, ofr_pkg::CMD_WRDI, ofr_pkg::CMD_RSTEN,
              ofr_pkg::CMD_RST, ofr_pkg::CMD_CLSR, ofr_pkg::CMD_CE: begin
                st_nxt = ofr_pkg::ST_DONE;
              end
              ofr_pkg::CMD_RDSR: begin
                st_nxt = ofr_pkg::ST_RDATA;
              end
              ofr_pkg::CMD_RDREG, ofr_pkg::CMD_WRREG, ofr_pkg::CMD_PP,
              ofr_pkg::CMD_SE4K, ofr_pkg::CMD_SFDP: begin
                st_nxt = ofr_pkg::ST_ADDR;
              end
              default: begin
                st_nxt = ofr_pkg::ST_IGNORE;
              end
            endcase
          end
        end
        ofr_pkg::ST_ADDR: begin
          if (addr_last) begin
            case (cmd_r)
              ofr_pkg::CMD_RDREG, ofr_pkg::CMD_SFDP: begin
                st_nxt = (rd_dummy == 5'h00) ? ofr_pkg::ST_RDATA : ofr_pkg::ST_DUMMY;
              end
              ofr_pkg::CMD_SE4K: begin
                st_nxt = ofr_pkg::ST_DONE;
              end
              default: begin
                st_nxt = ofr_pkg::ST_WDATA;
              end
            endcase
          end
        end
        ofr_pkg::ST_DUMMY: begin
          if (lk.rise && dcnt_r == 5'h01) begin
            st_nxt = ofr_pkg::ST_RDATA;
          end
        end
        ofr_pkg::ST_WDATA: begin
          if (byte_done && cmd_r == ofr_pkg::CMD_WRREG) begin
            st_nxt = ofr_pkg::ST_DONE;
          end
        end
        default: begin
          st_nxt = st_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      st_r <= ofr_pkg::ST_CMD;
      act_d_r <= 1'b0;
      bcnt_r <= 3'h0;
      sh_r <= 7'h00;
      cmd_r <= 8'h00;
      addr_r <= 24'h000000;
      acnt_r <= 2'h0;
      dcnt_r <= 5'h00;
      dlen_r <= 5'h00;
      wdat_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      act_d_r <= lk.act;
      bcnt_r <= !lk.act ? 3'h0 : (lk.rise && rx_st) ? bcnt_r + 3'h1 : bcnt_r;
      sh_r <= (lk.rise && rx_st) ? {sh_r[5:0], lk.dq[0]} : sh_r;
      if (byte_done && st_r == ofr_pkg::ST_CMD) begin
        cmd_r <= rx_byte;
        acnt_r <= 2'h0;
      end
      if (byte_done && st_r == ofr_pkg::ST_ADDR) begin
        addr_r <= addr_nxt;
        acnt_r <= acnt_r + 2'h1;
      end
      if (addr_last) begin
        dcnt_r <= rd_dummy;
        dlen_r <= rd_dummy;
      end else if (lk.rise && st_r == ofr_pkg::ST_DUMMY) begin
        dcnt_r <= dcnt_r - 5'h01;
      end
      if (byte_done && st_r == ofr_pkg::ST_WDATA) begin
        wdat_r <= rx_byte;
      end
    end
  end

  // ****************************************
  // read output, changed on falling edges
  // ****************************************
  always_ff @(posedge clk_in) begin
    if (rst_in || !lk.act) begin
      obit_r <= 3'h0;
      dq_r <= 8'h00;
      oe_n_r <= 1'b1;
    end else if (lk.fall && st_r == ofr_pkg::ST_RDATA) begin
      obit_r <= obit_r + 3'h1;
      dq_r <= lk.octal ? rd_val : {6'h00, rd_val[~obit_r], 1'b0};
      oe_n_r <= 1'b0;
    end
  end

  // ****************************************
  // command execution at frame end
  // ****************************************
  wire frame_end = act_d_r & ~lk.act;
  wire done_ok = frame_end & ((st_r == ofr_pkg::ST_DONE)
                 | (st_r == ofr_pkg::ST_WDATA && cmd_r == ofr_pkg::CMD_PP));
  wire ex_wren = done_ok & (cmd_r == ofr_pkg::CMD_WREN);
  wire ex_wrdi = done_ok & (cmd_r == ofr_pkg::CMD_WRDI);
  wire ex_clsr = done_ok & (cmd_r == ofr_pkg::CMD_CLSR);
  wire ex_rst = done_ok & (cmd_r == ofr_pkg::CMD_RST) & arm_r & ~busy_r;
  wire wr_ok = done_ok & wel_r & ~busy_r;
  wire ex_wrv = wr_ok & (cmd_r == ofr_pkg::CMD_WRREG) & loc_cfg & is_vol;
  wire ex_wrnv = wr_ok & (cmd_r == ofr_pkg::CMD_WRREG) & loc_cfg & ~is_vol;
  wire ex_prog = wr_ok & (cmd_r == ofr_pkg::CMD_PP);
  wire ex_erase = wr_ok & ((cmd_r == ofr_pkg::CMD_SE4K) | (cmd_r == ofr_pkg::CMD_CE));
  wire op_end = busy_r & (tmr_r == 16'h0000);

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      busy_r <= 1'b0;
      wel_r <= 1'b0;
      pfail_r <= 1'b0;
      efail_r <= 1'b0;
      arm_r <= 1'b0;
      op_r <= ofr_pkg::OP_NONE;
      tmr_r <= 16'h0000;
      nvdat_r <= 8'h00;
      cfg_nv_r <= ofr_pkg::CFG2_RESET;
      cfg_v_r <= ofr_pkg::CFG2_RESET;
    end else begin
      if (done_ok) begin
        arm_r <= cmd_r == ofr_pkg::CMD_RSTEN;
      end
      if (ex_wren) begin
        wel_r <= 1'b1;
      end else if (ex_wrdi || ex_wrv || ex_rst || op_end) begin
        wel_r <= 1'b0;
      end
      if (ex_rst) begin
        cfg_v_r <= cfg_nv_r;
      end else if (ex_wrv) begin
        cfg_v_r <= wdat_r;
      end else if (op_end && op_r == ofr_pkg::OP_NVW) begin
        cfg_v_r <= nvdat_r;
      end
      if (op_end && op_r == ofr_pkg::OP_NVW) begin
        cfg_nv_r <= nvdat_r;
      end
      // completion wins over a clear in the same cycle
      if (op_end && op_r == ofr_pkg::OP_PROG) begin
        pfail_r <= prog_fail_in;
      end else if (ex_clsr || ex_rst) begin
        pfail_r <= 1'b0;
      end
      if (op_end && op_r == ofr_pkg::OP_ERASE) begin
        efail_r <= erase_fail_in;
      end else if (ex_clsr || ex_rst) begin
        efail_r <= 1'b0;
      end
      if (ex_prog || ex_erase || ex_wrnv) begin
        busy_r <= 1'b1;
        tmr_r <= 16'(OP_CYCLES - 1);
        nvdat_r <= wdat_r;
        op_r <= ex_prog ? ofr_pkg::OP_PROG : ex_erase ? ofr_pkg::OP_ERASE : ofr_pkg::OP_NVW;
      end else if (op_end) begin
        busy_r <= 1'b0;
        op_r <= ofr_pkg::OP_NONE;
      end else if (busy_r) begin
        tmr_r <= tmr_r - 16'h0001;
      end
    end
  end

  assign dq_out = dq_r;
  assign dq_oe_n_out = oe_n_r;
  assign op_busy_flag_out = busy_r;
  assign write_latch_flag_out = wel_r;
  assign latency_code_out = lat_code;

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence nv_oct_rd(logic [3:0] c);
    addr_last && is_rdreg && !nxt_vol && lk.octal && lat_code == c;
  endsequence

  lat_200_a: assert property (nv_oct_rd(ofr_pkg::LAT_CODE_200) |=> dlen_r == 5'h17)
    else $error("200 MHz latency is not 23");
  lat_166_a: assert property (nv_oct_rd(ofr_pkg::LAT_CODE_166) |=> dlen_r == 5'h14)
    else $error("166 MHz latency is not 20");
  lat_133_a: assert property (nv_oct_rd(ofr_pkg::LAT_CODE_133) |=> dlen_r == 5'h0e)
    else $error("133 MHz latency is not 14");
  lat_100_a: assert property (nv_oct_rd(ofr_pkg::LAT_CODE_100) |=> dlen_r == 5'h0a)
    else $error("100 MHz latency is not 10");
  vol_lat_a: assert property (addr_last && is_rdreg && nxt_vol |=>
      dlen_r == (lk.octal ? 5'h03 : 5'h00))
    else $error("volatile read latency wrong");
  addr_three_a: assert property ($rose(st_r == ofr_pkg::ST_DUMMY) |-> acnt_r == 2'h3)
    else $error("dummy phase before three address bytes");
  wel_set_a: assert property (ex_wren |=> wel_r ##1 stat[1])
    else $error("write latch not set by 06h");
  busy_hold_a: assert property ($rose(busy_r) |-> busy_r [*8] ##0 stat[0])
    else $error("busy bit not held");
  pfail_a: assert property (op_end && op_r == ofr_pkg::OP_PROG |=>
      pfail_r == $past(prog_fail_in))
    else $error("program failure flag wrong");
  efail_a: assert property (op_end && op_r == ofr_pkg::OP_ERASE |=>
      efail_r == $past(erase_fail_in))
    else $error("erase failure flag wrong");
  nv_write_a: assert property (ex_wrnv |=> busy_r && op_r == ofr_pkg::OP_NVW)
    else $error("non-volatile write did not start");

endmodule

`default_nettype wire

//--- tb/octal_flash_register_access_tb_top.sv
/*
  Self-checking bench for the register access engine.
  Assumes: ofr_host_model stands on the link; busy time shortened to 200 clk.
*/
`timescale 1ns/1ps
`default_nettype none

module octal_flash_register_access_tb_top;
  localparam int CEIL = 60000;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic prog_fail = 1'b0;
  logic erase_fail = 1'b0;
  logic cs_n, sck, octal, dq_oe_n, busy, latch;
  logic [7:0] dq_h2d, dq_d2h, d;
  logic [3:0] lat_code;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [3:0] codes [4] = '{4'ha, 4'h8, 4'h5, 4'h3};
  int dummies [4] = '{23, 20, 14, 10};

  always #2 clk_in = ~clk_in;

  ofr_host_model u_host (.clk_in(clk_in), .cs_n_out(cs_n), .sck_out(sck),
    .octal_out(octal), .dq_out(dq_h2d), .dq_in(dq_d2h), .dq_oe_n_in(dq_oe_n));

  ofr_regs #(.OP_CYCLES(200)) u_dut (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n),
    .sck_in(sck), .octal_mode_in(octal), .dq_in(dq_h2d), .dq_out(dq_d2h),
    .dq_oe_n_out(dq_oe_n), .prog_fail_in(prog_fail), .erase_fail_in(erase_fail),
    .op_busy_flag_out(busy), .write_latch_flag_out(latch), .latency_code_out(lat_code));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic op_check(input logic [7:0] cmd, input int nadr, input logic [7:0] exp);
    u_host.wren();
    u_host.frame(cmd, nadr, 24'h000100, 0, 8'h00, 0, 0, d);
    u_host.wait_ready(d);
    check(d, exp);
  endtask

  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check({4'h0, lat_code}, ofr_pkg::CFG2_RESET);
    u_host.rdreg(24'h800003, 3, d);
    check(d, ofr_pkg::CFG2_RESET);
    u_host.status(d);
    check(d, 8'h00);
    check({7'h00, dq_oe_n}, 8'h01);
    u_host.wren();
    check({7'h00, latch}, 8'h01);
    u_host.rdreg(24'h800000, 3, d);
    check(d, 8'h02);
    $display("test reset and latch done");
    for (int i = 0; i < 4; i++) begin
      u_host.wrreg(24'h000003, {4'h0, codes[i]});
      check({7'h00, busy}, 8'h01);
      u_host.status(d);
      check({7'h00, d[0]}, 8'h01);
      u_host.wait_ready(d);
      check(d, 8'h00);
      u_host.rdreg(24'h000003, dummies[i], d);
      check(d, {4'h0, codes[i]});
      check({4'h0, lat_code}, {4'h0, codes[i]});
    end
    $display("test latency table done");
    u_host.wrreg(24'h800003, 8'h05);
    check({4'h0, lat_code}, 8'h05);
    u_host.rdreg(24'h800003, 3, d);
    check(d, 8'h05);
    u_host.frame(ofr_pkg::CMD_RST, 0, 24'h000000, 0, 8'h00, 0, 0, d);
    check({4'h0, lat_code}, 8'h05);
    u_host.soft_reset();
    check({4'h0, lat_code}, 8'h03);
    u_host.set_mode(1'b0);
    u_host.rdreg(24'h800003, 0, d);
    check(d, 8'h03);
    u_host.rdreg(24'h000003, 8, d);
    check(d, 8'h03);
    u_host.wren();
    u_host.status(d);
    check(d, 8'h02);
    u_host.set_mode(1'b1);
    $display("test volatile and single wire done");
    prog_fail <= 1'b1;
    u_host.wren();
    u_host.frame(ofr_pkg::CMD_PP, 3, 24'h000100, 1, 8'h5a, 0, 0, d);
    u_host.wait_ready(d);
    check(d, 8'h40);
    u_host.frame(ofr_pkg::CMD_CLSR, 0, 24'h000000, 0, 8'h00, 0, 0, d);
    u_host.status(d);
    check(d, 8'h00);
    prog_fail <= 1'b0;
    erase_fail <= 1'b1;
    op_check(ofr_pkg::CMD_SE4K, 3, 8'h20);
    erase_fail <= 1'b0;
    op_check(ofr_pkg::CMD_CE, 0, 8'h00);
    u_host.wren();
    u_host.frame(8'h52, 3, 24'h000100, 0, 8'h00, 0, 0, d);
    check({7'h00, busy}, 8'h00);
    u_host.status(d);
    check(d, 8'h02);
    u_host.frame(ofr_pkg::CMD_SFDP, 3, 24'h000000, 0, 8'h00, 8, 1, d);
    check(d, 8'h00);
    $display("test operations done");
    rst_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    rst_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    check({4'h0, lat_code}, ofr_pkg::CFG2_RESET);
    check({7'h00, latch}, 8'h00);
    u_host.rdreg(24'h000003, 20, d);
    check(d, ofr_pkg::CFG2_RESET);
    u_host.status(d);
    check(d, 8'h00);
    $display("test mid-run reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- tb/ofr_host_model.sv
/*
  Host controller model that drives the flash register link.
  Assumes: clk_in is the bench clock and the serial clock half period is
  20 clk_in cycles; the serial clock stands low outside frames.
*/
`timescale 1ns/1ps
`default_nettype none

module ofr_host_model (
  // clock
  input wire logic clk_in,
  // link pins
  output logic cs_n_out,
  output logic sck_out,
  output logic octal_out,
  output logic [7:0] dq_out,
  input wire logic [7:0] dq_in,
  input wire logic dq_oe_n_in
);
  localparam int HALF = 20;

  initial begin
    cs_n_out = 1'b1;
    sck_out = 1'b0;
    octal_out = 1'b1;
    dq_out = 8'h00;
  end

  // mode settles before the next frame reads it
  task automatic set_mode(input logic m);
    octal_out <= m;
    @(posedge clk_in);
  endtask

  // one serial clock pulse, reply taken before the rising edge
  // released data lines read back inverted
  task automatic pulse(output logic [7:0] q);
    repeat (HALF) @(posedge clk_in);
    q = dq_oe_n_in ? ~dq_in : dq_in;
    sck_out <= 1'b1;
    repeat (HALF) @(posedge clk_in);
    sck_out <= 1'b0;
  endtask

  task automatic send(input logic [7:0] b);
    logic [7:0] q;
    if (octal_out) begin
      dq_out <= b;
      pulse(q);
    end else begin
      for (int i = 7; i >= 0; i--) begin
        dq_out <= {7'h00, b[i]};
        pulse(q);
      end
    end
  endtask

  // released lines keep toggling so stale data never reads as valid
  task automatic idle_pulse(output logic [7:0] q);
    dq_out <= ~dq_out;
    pulse(q);
  endtask

  task automatic recv(output logic [7:0] b);
    logic [7:0] q;
    b = 8'h00;
    if (octal_out) begin
      idle_pulse(b);
    end else begin
      for (int i = 0; i < 8; i++) begin
        idle_pulse(q);
        b = {b[6:0], q[1]};
      end
    end
  endtask

  task automatic frame(input logic [7:0] cmd, input int nadr, input logic [23:0] adr,
                       input int nwr, input logic [7:0] wd, input int ndum,
                       input int nrd, output logic [7:0] rd);
    logic [7:0] q;
    rd = 8'h00;
    cs_n_out <= 1'b0;
    send(cmd);
    for (int i = 0; i < nadr; i++) begin
      send(adr[23 - 8 * i -: 8]);
    end
    for (int i = 0; i < nwr; i++) begin
      send(wd);
    end
    repeat (ndum) idle_pulse(q);
    for (int i = 0; i < nrd; i++) begin
      recv(rd);
    end
    repeat (HALF) @(posedge clk_in);
    cs_n_out <= 1'b1;
    repeat (HALF / 2) @(posedge clk_in);
  endtask

  task automatic wren();
    logic [7:0] q;
    frame(ofr_pkg::CMD_WREN, 0, 24'h000000, 0, 8'h00, 0, 0, q);
  endtask

  task automatic rdreg(input logic [23:0] adr, input int ndum, output logic [7:0] d);
    frame(ofr_pkg::CMD_RDREG, 3, adr, 0, 8'h00, ndum, 1, d);
  endtask

  task automatic wrreg(input logic [23:0] adr, input logic [7:0] v);
    logic [7:0] q;
    wren();
    frame(ofr_pkg::CMD_WRREG, 3, adr, 1, v, 0, 0, q);
  endtask

  task automatic status(output logic [7:0] d);
    frame(ofr_pkg::CMD_RDSR, 0, 24'h000000, 0, 8'h00, 0, 1, d);
  endtask

  task automatic wait_ready(output logic [7:0] d);
    for (int i = 0; i < 40; i++) begin
      status(d);
      if (d[0] === 1'b0) break;
    end
  endtask

  task automatic soft_reset();
    logic [7:0] q;
    frame(ofr_pkg::CMD_RSTEN, 0, 24'h000000, 0, 8'h00, 0, 0, q);
    frame(ofr_pkg::CMD_RST, 0, 24'h000000, 0, 8'h00, 0, 0, q);
  endtask
endmodule
`default_nettype wire
